// ### shared/sfb_regs.svh
// Constants for the serial page flash block: opcodes, field slices, lengths and times.
// Assumes inclusion by the package and by design files that need raw figures.
`ifndef SFB_REGS_SVH
`define SFB_REGS_SVH
// ==========================================================
// Opcodes
`define SFB_OP_PGRD 8'hD2
`define SFB_OP_BRD1F 8'hD4
`define SFB_OP_BRD1S 8'hD1
`define SFB_OP_BRD2F 8'hD6
`define SFB_OP_BRD2S 8'hD3
`define SFB_OP_BWR1 8'h84
`define SFB_OP_BWR2 8'h87
`define SFB_OP_PEP1 8'h83
`define SFB_OP_PEP2 8'h86
`define SFB_OP_PGM1 8'h88
`define SFB_OP_PGM2 8'h89
`define SFB_OP_PER 8'h81
// ==========================================================
// Frame layout, in bytes since chip select fell
`define SFB_HDR_PGRD 4'h8
`define SFB_HDR_BRD 4'h5
`define SFB_HDR_NONE 4'h0
`define SFB_ADR_LAST 4'h3
`define SFB_ADR_END 4'h4
`define SFB_CNT_MAX 4'hF
// ==========================================================
// Address fields and page geometry
`define SFB_STD_PG 20:9
`define SFB_BIN_PG 19:8
`define SFB_STD_BF 8:0
`define SFB_BIN_BF 7:0
`define SFB_LEN_STD 9'h108
`define SFB_LEN_BIN 9'h100
`define SFB_ERASED 8'hFF
`define SFB_PAGES 4096
// ==========================================================
// Self-timed operation times
`define SFB_MCLK_MHZ 25
`define SFB_T_EP_US 40
`define SFB_T_P_US 30
`define SFB_T_PE_US 30
`define SFB_T_EP_CYC (`SFB_T_EP_US * `SFB_MCLK_MHZ)
`define SFB_T_P_CYC (`SFB_T_P_US * `SFB_MCLK_MHZ)
`define SFB_T_PE_CYC (`SFB_T_PE_US * `SFB_MCLK_MHZ)
`endif

// ### shared/sfb_pkg.sv
// Types and decode helpers shared by the flash core and its serial link.
// Assumes sfb_regs.svh is on the include path.
`default_nettype none
`include "sfb_regs.svh"
package sfb_pkg;
  typedef enum logic [2:0] {C_NONE, C_PGRD, C_BRD, C_BWR, C_PEP, C_PGM, C_PER} sfb_cmd_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_WAIT} sfb_state_e;
  typedef struct packed {logic [11:0] page; logic [8:0] bofs;} sfb_addr_s;
  // ==========================================================
  // Opcode decoding
  function automatic sfb_cmd_e sfb_cmd_of(input logic [7:0] op);
    case (op)
      `SFB_OP_PGRD: return C_PGRD;
      `SFB_OP_BRD1F, `SFB_OP_BRD1S, `SFB_OP_BRD2F, `SFB_OP_BRD2S: return C_BRD;
      `SFB_OP_BWR1, `SFB_OP_BWR2: return C_BWR;
      `SFB_OP_PEP1, `SFB_OP_PEP2: return C_PEP;
      `SFB_OP_PGM1, `SFB_OP_PGM2: return C_PGM;
      `SFB_OP_PER: return C_PER;
      default: return C_NONE;
    endcase
  endfunction
  // Second buffer selected by these opcodes
  function automatic logic sfb_buf_of(input logic [7:0] op);
    return (op == `SFB_OP_BRD2F) || (op == `SFB_OP_BRD2S) || (op == `SFB_OP_BWR2) ||
           (op == `SFB_OP_PEP2) || (op == `SFB_OP_PGM2);
  endfunction
  // Bytes ahead of the first output byte, zero when nothing is output
  function automatic logic [3:0] sfb_hdr_len(input logic [7:0] op);
    case (sfb_cmd_of(op))
      C_PGRD: return `SFB_HDR_PGRD;
      C_BRD: return `SFB_HDR_BRD;
      default: return `SFB_HDR_NONE;
    endcase
  endfunction
  function automatic logic [8:0] sfb_page_len(input logic pb);
    return pb ? `SFB_LEN_BIN : `SFB_LEN_STD;
  endfunction
  // Page and byte fields; an out-of-page byte offset starts at zero
  function automatic sfb_addr_s sfb_split(input logic [23:0] a, input logic pb);
    sfb_addr_s r;
    r.page = pb ? a[`SFB_BIN_PG] : a[`SFB_STD_PG];
    r.bofs = pb ? {1'h0, a[`SFB_BIN_BF]} : a[`SFB_STD_BF];
    if (r.bofs >= sfb_page_len(pb)) r.bofs = 9'h000;
    return r;
  endfunction
  // Byte pointer step with wrap at page or buffer end
  function automatic logic [8:0] sfb_next(input logic [8:0] p, input logic pb);
    return (p >= sfb_page_len(pb) - 9'h001) ? 9'h000 : p + 9'h001;
  endfunction
endpackage
`default_nettype wire

// ### shared/sfb_link_if.sv
// Carrier between the serial link (serial clock domain) and the core (mclk domain).
// Toggles mark events; the byte beside each toggle holds still until the next one.
`default_nettype none
interface sfb_link_if;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic [7:0] tx_byte;
  logic tx_tgl;
  modport link (output rx_byte, output rx_tgl, output tx_tgl, input tx_byte);
  modport core (input rx_byte, input rx_tgl, input tx_tgl, output tx_byte);
endinterface
`default_nettype wire

// ### src/sfb_sync.sv
// Two-stage level synchroniser, one lane per bit.
// Assumes each lane is a level or a toggle that holds for several destination clocks.
`default_nettype none
module sfb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### src/sfb_link.sv
// Serial shifter on the host's clock: bytes in on rising edges, data out on falling.
// Assumes SPI mode 0 or 3; chip select high holds the frame logic in reset.
`default_nettype none
`include "sfb_regs.svh"
module sfb_link (
  input wire logic sck,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic si,
  sfb_link_if.link lk,
  output logic so,
  output logic so_oe
);
  import sfb_pkg::*;
  logic lrst;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [3:0] cnt_q;
  logic [7:0] op_q;
  logic [6:0] tx_q;
  logic [7:0] byte_w;
  logic ld;
  logic [3:0] hdr;
  // Frame ends asynchronously with chip select
  assign lrst = rst | cs_n;
  assign byte_w = {sh_q, si};
  assign hdr = sfb_hdr_len(op_q);
  // Load on the falling edge that opens a data byte
  assign ld = (bit_q == 3'h0) && (hdr != `SFB_HDR_NONE) && (cnt_q >= hdr); // RL4 RL12 RL1
  // ==========================================================
  // Receive: MSB first, one bit per rising edge
  always_ff @(posedge sck or posedge lrst) begin // RL24
    if (lrst) begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      cnt_q <= 4'h0;
      op_q <= 8'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q <= byte_w[6:0]; // RL25
      if (bit_q == 3'h7 && cnt_q == 4'h0) op_q <= byte_w;
      if (bit_q == 3'h7 && cnt_q != `SFB_CNT_MAX) cnt_q <= cnt_q + 4'h1;
    end
  end
  // Event toggles survive chip select so no byte is lost at frame end
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      lk.rx_byte <= 8'h00;
      lk.rx_tgl <= 1'h0;
    end else if (!cs_n && bit_q == 3'h7) begin
      lk.rx_byte <= byte_w;
      lk.rx_tgl <= ~lk.rx_tgl;
    end
  end
  // ==========================================================
  // Transmit: released to high impedance when chip select rises
  always_ff @(negedge sck or posedge lrst) begin
    if (lrst) begin
      so <= 1'h0; // RL8
      so_oe <= 1'h0; // RL8
      tx_q <= 7'h00;
    end else if (ld) begin
      so <= lk.tx_byte[7];
      so_oe <= 1'h1;
      tx_q <= lk.tx_byte[6:0];
    end else begin
      so <= tx_q[6];
      tx_q <= {tx_q[5:0], 1'h0};
    end
  end
  always_ff @(negedge sck or posedge rst) begin
    if (rst) lk.tx_tgl <= 1'h0;
    else if (!cs_n && ld) lk.tx_tgl <= ~lk.tx_tgl;
  end
endmodule
`default_nettype wire

// ### src/sfb_flash_top.sv
// Serial page flash core: command decode, two SRAM buffers, page array, self-timed ops.
// Assumes a host SPI master on cs_n/sck/si; so and so_oe resolve outside.
//
// What this block does
// [RL1] Page read: opcode, three address bytes, four dummy bytes, then data.
// [RL2] Standard pages: twelve page bits then nine byte bits of 21.
// [RL3] Binary pages: upper twelve bits page, lower eight bits byte of 20.
// [RL4] After the dummy bytes, one data bit per further serial clock.
// [RL5] Page read wraps to the start of the same page.
// [RL6] Page read leaves both buffers untouched.
// [RL7] Host keeps chip select low through every phase of a read.
// [RL8] Chip select rising ends a read and floats the output.
// [RL9] Buffer read opcodes D4/D1 pick buffer 1, D6/D3 buffer 2.
// [RL10] Host uses D4/D6 at high clock rates, D1/D3 only slower.
// [RL11] Buffer byte address is low nine or low eight address bits.
// [RL12] Buffer read: exactly one dummy byte before data.
// [RL13] Buffer read wraps to location zero.
// [RL14] Buffer write 84 to buffer 1, 87 to buffer 2, from given byte.
// [RL15] Written bytes go to rising locations, wrapping to zero.
// [RL16] Buffer write continues until chip select rises.
// [RL17] Program with erase: 83 buffer 1, 86 buffer 2.
// [RL18] Program and erase take a twelve bit page field.
// [RL19] Program with erase: erase page to ones, then program buffer.
// [RL20] Program without erase: 88 buffer 1, 89 buffer 2.
// [RL21] Host only programs without erase into an erased page.
// [RL22] Opcode 81 erases the addressed page to all ones.
// [RL23] Busy shows while a self-timed operation runs.
// [RL24] Serial link works in SPI modes 0 and 3.
// [RL25] MSB first; self-timed ops need opcode and three address bytes.
`default_nettype none
`include "sfb_regs.svh"
module sfb_flash_top #(
  parameter int PAGES = `SFB_PAGES,
  parameter int T_EP = `SFB_T_EP_CYC,
  parameter int T_P = `SFB_T_P_CYC,
  parameter int T_PE = `SFB_T_PE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic page_bin,
  output logic so,
  output logic so_oe,
  output logic busy
);
  import sfb_pkg::*;
  localparam int ADR_W = $clog2(PAGES * int'(`SFB_LEN_STD));
  // ==========================================================
  // Storage: page array and two buffers
  logic [7:0] arr_mem [PAGES * int'(`SFB_LEN_STD)];
  logic [7:0] buf_mem [2][int'(`SFB_LEN_STD)];
  // ==========================================================
  // Declarations
  logic [3:0] sy;
  logic sel_q;
  logic rxs_q;
  logic txs_q;
  logic rx_ev;
  logic tx_ev;
  logic cs_fall;
  logic cs_rise;
  logic pb;
  logic [8:0] plen;
  logic [3:0] cnt_q;
  logic [7:0] op_q;
  logic [15:0] adr_q;
  logic act_q;
  sfb_cmd_e cmd;
  logic bsel;
  logic [23:0] full_adr;
  sfb_addr_s split;
  logic adr_done;
  logic is_rd;
  logic wr_en;
  logic pf_q;
  logic pf;
  logic [8:0] ptr_q;
  logic [11:0] page_q;
  logic [7:0] tx_q;
  logic [ADR_W-1:0] rd_idx;
  logic is_op;
  logic launch;
  sfb_state_e st_q;
  logic [15:0] tmr_q;
  logic [8:0] j_q;
  logic opb_q;
  logic [11:0] opage_q;
  logic pep_q;
  logic busy_q;
  logic [ADR_W-1:0] op_idx;
  logic j_last;
  sfb_link_if lnk();
  // ==========================================================
  // Serial link on the host's clock
  sfb_link u_link (
    .sck(sck),
    .rst(rst),
    .cs_n(cs_n),
    .si(si),
    .lk(lnk.link),
    .so(so),
    .so_oe(so_oe)
  );
  // Chip select, strap and link toggles cross into mclk
  sfb_sync #(.W(4)) u_sync (
    .clk(mclk),
    .rst(rst),
    .d({~cs_n, page_bin, lnk.rx_tgl, lnk.tx_tgl}),
    .q(sy)
  );
  // Edge memory of the synchronised lanes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_q <= 1'h0;
      rxs_q <= 1'h0;
      txs_q <= 1'h0;
    end else begin
      sel_q <= sy[3];
      rxs_q <= sy[1];
      txs_q <= sy[0];
    end
  end
  // Event decode; strap may change only between frames
  assign cs_fall = sy[3] & ~sel_q;
  assign cs_rise = ~sy[3] & sel_q;
  assign pb = sy[2];
  assign rx_ev = sy[1] ^ rxs_q;
  assign tx_ev = sy[0] ^ txs_q;
  assign plen = sfb_page_len(pb);
  // ==========================================================
  // Frame capture: opcode and address bytes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      op_q <= 8'h00;
      adr_q <= 16'h0000;
      act_q <= 1'h0;
    end else if (cs_fall) begin
      cnt_q <= 4'h0;
      op_q <= 8'h00;
      act_q <= (st_q == ST_IDLE); // Commands ignored while busy
    end else if (rx_ev) begin
      if (cnt_q == 4'h0) op_q <= lnk.rx_byte;
      if (cnt_q != 4'h0 && cnt_q <= `SFB_ADR_LAST) adr_q <= {adr_q[7:0], lnk.rx_byte};
      if (cnt_q != `SFB_CNT_MAX) cnt_q <= cnt_q + 4'h1;
    end
  end
  // Command decode
  assign cmd = sfb_cmd_of(op_q); // RL9 RL14 RL17 RL20 RL22
  assign bsel = sfb_buf_of(op_q); // RL9 RL14 RL17 RL20
  assign full_adr = {adr_q, lnk.rx_byte};
  assign split = sfb_split(full_adr, pb); // RL2 RL3 RL11 RL18
  assign adr_done = rx_ev && act_q && (cnt_q == `SFB_ADR_LAST);
  assign is_rd = (cmd == C_PGRD) || (cmd == C_BRD);
  // Bytes past the address are buffer data while the frame is open
  assign wr_en = rx_ev && act_q && (cmd == C_BWR) && (cnt_q >= `SFB_ADR_END); // RL15 RL16
  // ==========================================================
  // Read prefetch: next byte waits in tx_q ahead of the link
  assign pf = pf_q | (tx_ev & act_q & is_rd);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) pf_q <= 1'h0;
    else pf_q <= adr_done && is_rd;
  end
  // Byte pointer and page field, shared by reads and buffer writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptr_q <= 9'h000;
      page_q <= 12'h000;
    end else if (adr_done) begin
      page_q <= split.page; // RL2 RL3 RL18
      ptr_q <= split.bofs; // RL11 RL14
    end else if (wr_en || pf) begin
      ptr_q <= sfb_next(ptr_q, pb); // RL5 RL13 RL15
    end
  end
  // Main array is read in place; buffers are only read here, never written
  assign rd_idx = ADR_W'(page_q) * ADR_W'(`SFB_LEN_STD) + ADR_W'(ptr_q);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) tx_q <= 8'h00;
    else if (pf && cmd == C_PGRD) tx_q <= arr_mem[rd_idx]; // RL6
    else if (pf) tx_q <= buf_mem[bsel][ptr_q]; // RL13
  end
  // Held still for the link until the next taken toggle
  assign lnk.tx_byte = tx_q;
  // Buffer write port
  always_ff @(posedge mclk) begin
    if (wr_en) buf_mem[bsel][ptr_q] <= lnk.rx_byte; // RL14 RL15
  end
  // ==========================================================
  // Self-timed program and erase
  assign is_op = (cmd == C_PEP) || (cmd == C_PGM) || (cmd == C_PER);
  // A short header is dropped at chip select rising
  assign launch = cs_rise && act_q && is_op && (cnt_q >= `SFB_ADR_END) &&
                  (st_q == ST_IDLE); // RL25
  assign j_last = (j_q >= plen - 9'h001);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      tmr_q <= 16'h0000;
      j_q <= 9'h000;
      opb_q <= 1'h0;
      opage_q <= 12'h000;
      pep_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      if (st_q != ST_IDLE && tmr_q != 16'h0000) tmr_q <= tmr_q - 16'h0001;
      case (st_q)
        ST_IDLE: begin
          if (launch) begin
            busy_q <= 1'h1; // RL23
            j_q <= 9'h000;
            opb_q <= bsel;
            opage_q <= page_q;
            pep_q <= (cmd == C_PEP);
            if (cmd == C_PGM) begin
              st_q <= ST_PROG; // RL20
              tmr_q <= 16'(T_P);
            end else begin
              st_q <= ST_ERASE; // RL19 RL22
              tmr_q <= (cmd == C_PEP) ? 16'(T_EP) : 16'(T_PE);
            end
          end
        end
        ST_ERASE: begin
          j_q <= j_last ? 9'h000 : j_q + 9'h001;
          if (j_last) st_q <= pep_q ? ST_PROG : ST_WAIT; // RL19
        end
        ST_PROG: begin
          j_q <= j_last ? 9'h000 : j_q + 9'h001;
          if (j_last) st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // Busy stands out the whole rated time
          if (tmr_q == 16'h0000) begin
            st_q <= ST_IDLE;
            busy_q <= 1'h0; // RL23
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign busy = busy_q;
  // Array writes: one byte per cycle; program only clears bits
  assign op_idx = ADR_W'(opage_q) * ADR_W'(`SFB_LEN_STD) + ADR_W'(j_q);
  always_ff @(posedge mclk) begin
    if (st_q == ST_ERASE) arr_mem[op_idx] <= `SFB_ERASED; // RL19 RL22
    else if (st_q == ST_PROG) arr_mem[op_idx] <= arr_mem[op_idx] & buf_mem[opb_q][j_q]; // RL20
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_erase_run;
    (st_q == ST_ERASE && busy_q)[*4];
  endsequence
  sequence s_prog_start;
    st_q == ST_PROG && j_q == 9'h000 && busy_q;
  endsequence
  property p_pep_erase;
    launch && cmd == C_PEP |=> s_erase_run;
  endproperty
  a_pep_erase: assert property (p_pep_erase) else $error("erase phase missing"); // RL19
  property p_pep_prog;
    st_q == ST_ERASE && j_last && pep_q |=> s_prog_start;
  endproperty
  a_pep_prog: assert property (p_pep_prog) else $error("no program after erase"); // RL19
  property p_pgm;
    launch && cmd == C_PGM |=> s_prog_start ##1 st_q == ST_PROG;
  endproperty
  a_pgm: assert property (p_pgm) else $error("program did not start"); // RL20
  property p_per;
    st_q == ST_ERASE && j_last && !pep_q |=> st_q == ST_WAIT && busy_q;
  endproperty
  a_per: assert property (p_per) else $error("page erase did not end in wait"); // RL22
  property p_busy;
    (st_q != ST_IDLE) |-> busy_q && (!$rose(busy_q) || $past(launch));
  endproperty
  a_busy: assert property (p_busy) else $error("busy wrong during operation"); // RL23
  property p_short;
    cs_rise && st_q == ST_IDLE && cnt_q < `SFB_ADR_END |=> (st_q == ST_IDLE && !busy_q)[*2];
  endproperty
  a_short: assert property (p_short) else $error("short command started"); // RL25
  property p_rd_keep;
    cmd == C_PGRD |-> !wr_en;
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("page read wrote a buffer"); // RL6
  property p_rd_wrap;
    pf && !adr_done && ptr_q == plen - 9'h001 |=> ptr_q == 9'h000;
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) else $error("read pointer did not wrap"); // RL5
  property p_wr_wrap;
    wr_en && ptr_q == plen - 9'h001 |=> ptr_q == 9'h000;
  endproperty
  a_wr_wrap: assert property (p_wr_wrap) else $error("write pointer did not wrap"); // RL15
  property p_std_split;
    adr_done && !pb |=> page_q == $past(full_adr[20:9]);
  endproperty
  a_std_split: assert property (p_std_split) else $error("standard page field wrong"); // RL2
  property p_bin_split;
    adr_done && pb |=> page_q == $past(full_adr[19:8]) ##0 ptr_q[8] == 1'h0;
  endproperty
  a_bin_split: assert property (p_bin_split) else $error("binary page field wrong"); // RL3
  // Busy may only drop once the rated time has run out
  property p_busy_hold;
    busy_q && tmr_q != 16'h0000 |=> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early"); // RL23
  // A launched operation shows busy on the next cycle
  property p_launch;
    launch |=> busy_q && st_q != ST_IDLE;
  endproperty
  a_launch: assert property (p_launch) else $error("launch without busy"); // RL23
  // Wait state ends the operation right at timer expiry
  property p_wait_end;
    st_q == ST_WAIT && tmr_q == 16'h0000 |=> st_q == ST_IDLE && !busy_q;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("busy stuck after timer"); // RL23
  // Standard byte field, clamped to zero past the page end
  property p_std_byte;
    adr_done && !pb |=> ptr_q == ($past(full_adr[8:0]) < `SFB_LEN_STD ? $past(full_adr[8:0]) : 9'h000);
  endproperty
  a_std_byte: assert property (p_std_byte) else $error("standard byte field wrong"); // RL2
  // Buffer data lands at rising locations
  property p_wr_step;
    wr_en && ptr_q != plen - 9'h001 |=> ptr_q == $past(ptr_q) + 9'h001;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write pointer skipped"); // RL15
  // Each erase step leaves its byte at all ones
  property p_erase_fill;
    st_q == ST_ERASE |=> arr_mem[$past(op_idx)] == `SFB_ERASED;
  endproperty
  a_erase_fill: assert property (p_erase_fill) else $error("erased byte not all ones"); // RL22
  // Page erase opens with its erase pass
  property p_per_run;
    launch && cmd == C_PER |=> s_erase_run;
  endproperty
  a_per_run: assert property (p_per_run) else $error("page erase did not start"); // RL22
  // First read byte is fetched from inside the page or buffer
  property p_rd_start;
    pf_q |-> ptr_q < plen;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read start out of range"); // RL11
endmodule
`default_nettype wire

// ### testbench/sfb_host_model.sv
// Host SPI master model for the serial page flash: chip select, clock, data in.
// Assumes the bench calls its tasks one frame at a time; mode chosen by cpol.
`default_nettype none
module sfb_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // State and idle levels
  logic cpol = 1'b0; // 0 gives mode 0, 1 gives mode 3
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end
  // ==========================================================
  // Frame tasks
  // Gap first, so busy can be timed right after frame_end returns
  task automatic frame_begin();
    #200;
    sck = cpol; // Clock parked at its idle level outside frames
    #7 cs_n = 1'b0;
    #40;
  endtask
  // One byte out and in, sampled on the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (cpol) sck = 1'b0;
      si = tx[i];
      #40 sck = 1'b1;
      rx[i] = so;
      #40;
      if (!cpol) sck = 1'b0;
    end
  endtask
  // Release: data line shows the inverse so stale values cannot match
  task automatic frame_end();
    #40 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the serial page flash core.
// Assumes sfb_flash_top with small self-timed counts and a host model on its pins.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T_EP = 600;
  localparam int T_P = 300;
  localparam int T_PE = 300;
  // ==========================================================
  // Signals and instances
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic page_bin = 1'b0;
  logic sck, cs_n, si, so, so_oe, busy;
  logic so_line;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  sfb_flash_top #(.PAGES(8), .T_EP(T_EP), .T_P(T_P), .T_PE(T_PE)) i_sfb_flash_top (
    .mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .page_bin(page_bin),
    .so(so), .so_oe(so_oe), .busy(busy));
  // Undriven line reads inverted so a late enable cannot pass
  assign so_line = so_oe ? so : ~so;
  sfb_host_model i_sfb_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));
  // Core clock, 40 ns period
  always #20 mclk = ~mclk;
  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, well above the roughly 13000 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========================================================
  // Frame helpers
  // Source 0 and 1 are the two buffer patterns, 2 is erased flash
  function automatic logic [7:0] pat(input int src, input int i);
    return src == 2 ? 8'hFF : (src == 0 ? i[7:0] ^ 8'h5A : ~i[7:0]);
  endfunction
  task automatic send_hdr(input logic [7:0] op, input logic [23:0] a, input int nd);
    logic [7:0] r;
    i_sfb_host_model.frame_begin();
    i_sfb_host_model.xfer(op, r);
    i_sfb_host_model.xfer(a[23:16], r);
    i_sfb_host_model.xfer(a[15:8], r);
    i_sfb_host_model.xfer(a[7:0], r);
    repeat (nd) i_sfb_host_model.xfer(8'h00, r);
  endtask
  // Whole buffer written once from the given start; a mid-buffer start makes the pointer wrap
  task automatic fill(input logic [7:0] op, input int src, input int start);
    logic [7:0] r;
    send_hdr(op, 24'(start), 0);
    for (int k = 0; k < 264; k++) i_sfb_host_model.xfer(pat(src, (start + k) % 264), r);
    i_sfb_host_model.frame_end();
  endtask
  task automatic read_chk(input logic [7:0] op, input logic [23:0] a, input int nd,
      input int src, input int start, input int len, input int n);
    logic [7:0] r;
    send_hdr(op, a, nd);
    for (int k = 0; k < n; k++) begin
      i_sfb_host_model.xfer(8'h00, r);
      check("read byte", 16'(r), 16'(pat(src, (start + k) % len)));
    end
    check("output enable", 16'(so_oe), 16'h0001);
    i_sfb_host_model.frame_end();
    @(negedge mclk);
    check("output float", 16'(so_oe), 16'h0000);
  endtask
  // Self-timed command, then its busy window counted on falling edges
  task automatic busy_cmd(input logic [7:0] op, input logic [23:0] a, input int len);
    int n;
    n = 0;
    send_hdr(op, a, 0);
    i_sfb_host_model.frame_end();
    @(negedge mclk);
    for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge mclk);
    while (busy === 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check("busy length", 16'(n), 16'(len + 1));
  endtask
  // ==========================================================
  // Scenarios
  // Writes into both buffers, buffer 1 wrapping, read back through all four opcodes
  task automatic s_buffers();
    fill(8'h84, 0, 'h106);
    fill(8'h87, 1, 0);
    read_chk(8'hD4, 24'hFFFF06, 1, 0, 'h106, 264, 4);
    read_chk(8'hD1, 24'h000000, 1, 0, 0, 264, 2);
    read_chk(8'hD6, 24'h000107, 1, 1, 'h107, 264, 3);
    read_chk(8'hD3, 24'h000005, 1, 1, 5, 264, 2);
  endtask
  // Program with erase, page read with wrap, buffer left intact
  task automatic s_program_erase();
    busy_cmd(8'h83, 24'hE00400, T_EP);
    read_chk(8'hD2, 24'h000505, 4, 0, 'h105, 264, 5);
    read_chk(8'hD4, 24'h000105, 1, 0, 'h105, 264, 3);
  endtask
  // Erase then program without erase, in mode 3
  task automatic s_erase_program();
    i_sfb_host_model.cpol = 1'b1;
    busy_cmd(8'h81, 24'h000600, T_PE);
    read_chk(8'hD2, 24'h000600, 4, 2, 0, 264, 3);
    busy_cmd(8'h89, 24'h000600, T_P);
    read_chk(8'hD2, 24'h000600, 4, 1, 0, 264, 3);
    busy_cmd(8'h81, 24'h000800, T_PE);
    busy_cmd(8'h88, 24'h000800, T_P);
    read_chk(8'hD2, 24'h000807, 4, 0, 7, 264, 2);
    i_sfb_host_model.cpol = 1'b0;
  endtask
  // Erase cut short after two address bytes must not start
  task automatic s_short_cmd();
    logic [7:0] r;
    i_sfb_host_model.frame_begin();
    i_sfb_host_model.xfer(8'h81, r);
    i_sfb_host_model.xfer(8'h00, r);
    i_sfb_host_model.xfer(8'h06, r);
    i_sfb_host_model.frame_end();
    repeat (30) @(negedge mclk);
    check("short command busy", 16'(busy), 16'h0000);
  endtask
  // Binary page size: buffer wrap at 256, page field a[19:8]
  task automatic s_binary();
    @(negedge mclk);
    page_bin = 1'b1;
    read_chk(8'hD4, 24'h0000FF, 1, 0, 255, 256, 2);
    busy_cmd(8'h86, 24'hF00100, T_EP);
    read_chk(8'hD2, 24'h0001FE, 4, 1, 254, 256, 3);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    check("idle busy", 16'(busy), 16'h0000);
    s_buffers();
    s_program_erase();
    s_erase_program();
    s_short_cmd();
    s_binary();
    final_report();
  end
endmodule
`default_nettype wire
